/* File: twc_defines.svh */
`ifndef TWC_DEFINES_SVH
`define TWC_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TWC_OFS_CONTROL 8'h00
`define TWC_OFS_MASTER_MODE 8'h04
`define TWC_OFS_INTERNAL_ADDRESS 8'h0C
`define TWC_OFS_CLOCK_WAVEFORM 8'h10
`define TWC_OFS_STATUS 8'h20
`define TWC_OFS_INTERRUPT_ENABLE 8'h24
`define TWC_OFS_INTERRUPT_DISABLE 8'h28
`define TWC_OFS_INTERRUPT_MASK 8'h2C
`define TWC_OFS_RECEIVE_HOLDING 8'h30
`define TWC_OFS_TRANSMIT_HOLDING 8'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TWC_CTRL_START 0
`define TWC_CTRL_STOP 1
`define TWC_CTRL_ENABLE 2
`define TWC_CTRL_DISABLE 3
`define TWC_CTRL_SOFT_RESET 7
`define TWC_MM_SIZE_LSB 8
`define TWC_MM_READ 12
`define TWC_MM_DEVICE_LSB 16
`define TWC_CW_LOW_LSB 0
`define TWC_CW_HIGH_LSB 8
`define TWC_CW_EXP_LSB 16
`define TWC_FLAG_COMPLETE 0
`define TWC_FLAG_RX_READY 1
`define TWC_FLAG_TX_READY 2
`define TWC_FLAG_OVERRUN 6
`define TWC_FLAG_UNDERRUN 7
`define TWC_FLAG_NOT_ACKED 8

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TWC_FLAGS_USED 9'h1C7
`define TWC_RESET_WORD 32'h0000_0000
`define TWC_PHASE_EXTRA 16'h0003

`endif

/* File: twc_pkg.sv */
package twc_pkg;

   // ----------------------------------------
   // Frame sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_BYTE,
      ST_RSTART,
      ST_STOP
   } twc_phase_t;

   // Kind of byte in the shifter
   typedef enum logic [1:0] {
      K_ADDR,
      K_IADDR,
      K_TXD,
      K_RXD
   } twc_kind_t;

   // ----------------------------------------
   // Controller state
   // ----------------------------------------
   typedef struct packed {
      twc_phase_t st;
      logic sda_pull;
      logic [7:0] shifter;
      logic [3:0] idx;
      twc_kind_t kind;
      logic [1:0] ia_left;
      logic last_rx;
      logic stop_req;
      logic [7:0] tx_hold;
      logic tx_valid;
      logic [7:0] rx_hold;
      logic [8:0] flags;
      logic [8:0] irq_mask;
      logic irq;
      logic [1:0] internal_address_size;
      logic read_direction_bit;
      logic [6:0] slave_device_address;
      logic [23:0] internal_address_value;
      logic [7:0] low_phase_divider;
      logic [7:0] high_phase_divider;
      logic [2:0] clock_divider_exponent;
      logic master_transfer_enable;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic hreadyout;
      logic [31:0] hrdata;
      logic sda_s1;
      logic sda_s2;
      logic scl_s1;
      logic scl_s2;
   } twc_ctl_t;

   // ----------------------------------------
   // Clock generator state
   // ----------------------------------------
   typedef struct packed {
      logic pull;
      logic parked;
      logic tick;
      logic [15:0] cnt;
   } twc_gen_t;

endpackage

/* File: twc_scl_if.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Sequencer to clock generator link
// ----------------------------------------
interface twc_scl_if;
   logic en; // Frame running
   logic park; // Stop at end of high phase
   logic scl_seen; // Synchronised clock line level
   logic [7:0] low_div; // Low phase divider
   logic [7:0] high_div; // High phase divider
   logic [2:0] div_exp; // Common exponent
   logic scl_pull; // Generator drives clock low
   logic parked; // Generator waits with clock high
   logic tick; // One cycle on every phase change
   modport ctl (output en, park, scl_seen, low_div, high_div, div_exp,
                input scl_pull, parked, tick);
   modport gen (input en, park, scl_seen, low_div, high_div, div_exp,
                output scl_pull, parked, tick);
endinterface

/* File: twc_scl_gen.sv */
`timescale 1ns/1ps
`include "twc_defines.svh"
module twc_scl_gen (
   input wire logic hclk,
   input wire logic hresetn,
   twc_scl_if.gen sc
);
   import twc_pkg::*;

   twc_gen_t q; // Registered state
   twc_gen_t d; // Next state

   // Phase length minus one, loaded into the down counter
   function automatic logic [15:0] phase_len(logic [7:0] div, logic [2:0] e);
      return (16'(div) << e) + `TWC_PHASE_EXTRA - 16'h0001;
   endfunction

   // ----------------------------------------
   // Phase sequencing
   // ----------------------------------------
   // The high phase only ends once the line is seen high, so a
   // slave that stretches the clock simply lengthens it.
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (!sc.en) begin
         // Idle: line released, counter primed for a high phase
         d.pull = 1'b0;
         d.parked = 1'b0;
         d.cnt = phase_len(sc.high_div, sc.div_exp);
      end else if (q.parked) begin
         // Leaving park starts a fresh high phase
         if (!sc.park) begin
            d.parked = 1'b0;
            d.cnt = phase_len(sc.high_div, sc.div_exp);
         end
      end else if (q.cnt != 16'h0000) begin
         d.cnt = q.cnt - 16'h0001;
      end else if (q.pull) begin
         d.pull = 1'b0;
         d.cnt = phase_len(sc.high_div, sc.div_exp);
         d.tick = 1'b1;
      end else if (sc.scl_seen) begin
         d.tick = 1'b1;
         if (sc.park) begin
            d.parked = 1'b1;
         end else begin
            d.pull = 1'b1;
            d.cnt = phase_len(sc.low_div, sc.div_exp);
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sc.scl_pull = q.pull;
   assign sc.parked = q.parked;
   assign sc.tick = q.tick;
endmodule

/* File: twc_two_wire_controller.sv */
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "twc_defines.svh"
module twc_two_wire_controller (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic serial_clock_line_i,
   output logic serial_clock_line_o,
   output logic serial_clock_line_oe,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe,
   output logic irq
);
   import twc_pkg::*;

   // ----------------------------------------
   // Reset image
   // ----------------------------------------
   // Bus ready high and both lines seen released
   localparam twc_ctl_t CTL_RST = '{
      st: ST_IDLE, kind: K_ADDR, hreadyout: 1'b1,
      sda_s1: 1'b1,
      sda_s2: 1'b1,
      scl_s1: 1'b1,
      scl_s2: 1'b1,
      default: '0
   };

   twc_ctl_t q; // Registered state
   twc_ctl_t d; // Next state
   logic accept; // Address phase taken
   logic start_cmd; // Frame start request this cycle
   logic soft_reset; // Software reset this cycle
   logic fall; // Clock line just went low
   logic park_tick; // Clock parked high
   logic bit_in; // Sampled data line
   logic [31:0] rv; // Read value

   twc_scl_if sc (); // Link to the clock generator

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Pick internal address byte n (3, 2 or 1), upper byte first
   function automatic logic [7:0] ia_byte(logic [23:0] v, logic [1:0] n);
      case (n)
         2'h3: ia_byte = v[23:16];
         2'h2: ia_byte = v[15:8];
         default: ia_byte = v[7:0];
      endcase
   endfunction

   // Hold data low during the low phase, release in high to rise
   function automatic twc_ctl_t go_stop(twc_ctl_t s);
      s.st = ST_STOP;
      s.sda_pull = 1'b1;
      return s;
   endfunction

   // Move the next byte to send into the shifter, or end the frame
   function automatic twc_ctl_t load_data(twc_ctl_t s);
      if (s.stop_req) begin
         s = go_stop(s);
      end else if (s.tx_valid) begin
         s.shifter = s.tx_hold;
         s.tx_valid = 1'b0;
         s.flags[`TWC_FLAG_TX_READY] = 1'b1;
         s.kind = K_TXD;
         s.sda_pull = ~s.tx_hold[7];
      end else begin
         // Nothing left to send: flag it and close the frame
         s.flags[`TWC_FLAG_UNDERRUN] = 1'b1;
         s = go_stop(s);
      end
      return s;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      rv = `TWC_RESET_WORD;
      start_cmd = 1'b0;
      soft_reset = 1'b0;
      fall = sc.tick && sc.scl_pull;
      park_tick = sc.tick && sc.parked;
      bit_in = q.sda_s2;

      // Two-stage synchronisers for both pins
      d.sda_s1 = serial_data_line_i;
      d.sda_s2 = q.sda_s1;
      d.scl_s1 = serial_clock_line_i;
      d.scl_s2 = q.scl_s1;

      // Address phase: whole-word transfers only
      accept = hsel && htrans[1] && hready && (hsize == 3'h2);
      d.ap_valid = accept;
      d.ap_write = hwrite;
      d.ap_addr = haddr[7:0];
      // Reads insert one wait state so data leaves a flop
      d.hreadyout = !(accept && !hwrite);

      // Write data phase
      if (q.ap_valid && q.ap_write) begin
         case (q.ap_addr)
            `TWC_OFS_CONTROL: begin
               start_cmd = hwdata[`TWC_CTRL_START];
               if (hwdata[`TWC_CTRL_STOP]) begin
                  d.stop_req = 1'b1;
               end
               if (hwdata[`TWC_CTRL_ENABLE] && !hwdata[`TWC_CTRL_DISABLE]) begin
                  d.master_transfer_enable = 1'b1;
                  d.flags[`TWC_FLAG_COMPLETE] = 1'b1;
                  d.flags[`TWC_FLAG_TX_READY] = 1'b1;
               end
               // Disabling only blocks new frames
               if (hwdata[`TWC_CTRL_DISABLE]) begin
                  d.master_transfer_enable = 1'b0;
               end
               soft_reset = hwdata[`TWC_CTRL_SOFT_RESET];
            end
            `TWC_OFS_MASTER_MODE: begin
               d.internal_address_size = hwdata[`TWC_MM_SIZE_LSB +: 2];
               d.read_direction_bit = hwdata[`TWC_MM_READ];
               d.slave_device_address = hwdata[`TWC_MM_DEVICE_LSB +: 7];
            end
            `TWC_OFS_INTERNAL_ADDRESS: begin
               d.internal_address_value = hwdata[23:0];
            end
            `TWC_OFS_CLOCK_WAVEFORM: begin
               d.low_phase_divider = hwdata[`TWC_CW_LOW_LSB +: 8];
               d.high_phase_divider = hwdata[`TWC_CW_HIGH_LSB +: 8];
               d.clock_divider_exponent = hwdata[`TWC_CW_EXP_LSB +: 3];
            end
            `TWC_OFS_INTERRUPT_ENABLE: begin
               d.irq_mask = q.irq_mask | (hwdata[8:0] & `TWC_FLAGS_USED);
            end
            `TWC_OFS_INTERRUPT_DISABLE: begin
               d.irq_mask = q.irq_mask & ~hwdata[8:0];
            end
            `TWC_OFS_TRANSMIT_HOLDING: begin
               d.tx_hold = hwdata[7:0];
               d.tx_valid = 1'b1;
               d.flags[`TWC_FLAG_TX_READY] = 1'b0;
               // In write direction a holding write alone starts a frame
               start_cmd = !q.read_direction_bit;
            end
            default: begin
               // Unmapped or read-only: write ignored
            end
         endcase
      end

      // Read data phase (the wait cycle) with its side effects
      if (q.ap_valid && !q.ap_write) begin
         case (q.ap_addr)
            `TWC_OFS_MASTER_MODE: begin
               rv[`TWC_MM_SIZE_LSB +: 2] = q.internal_address_size;
               rv[`TWC_MM_READ] = q.read_direction_bit;
               rv[`TWC_MM_DEVICE_LSB +: 7] = q.slave_device_address;
            end
            `TWC_OFS_INTERNAL_ADDRESS: begin
               rv[23:0] = q.internal_address_value;
            end
            `TWC_OFS_CLOCK_WAVEFORM: begin
               rv[`TWC_CW_LOW_LSB +: 8] = q.low_phase_divider;
               rv[`TWC_CW_HIGH_LSB +: 8] = q.high_phase_divider;
               rv[`TWC_CW_EXP_LSB +: 3] = q.clock_divider_exponent;
            end
            `TWC_OFS_STATUS: begin
               rv[8:0] = q.flags;
               d.flags[`TWC_FLAG_NOT_ACKED] = 1'b0;
               // Overrun and underrun only clear while the complete flag is set
               if (q.flags[`TWC_FLAG_COMPLETE]) begin
                  d.flags[`TWC_FLAG_OVERRUN] = 1'b0;
                  d.flags[`TWC_FLAG_UNDERRUN] = 1'b0;
               end
            end
            `TWC_OFS_INTERRUPT_MASK: begin
               rv[8:0] = q.irq_mask;
            end
            `TWC_OFS_RECEIVE_HOLDING: begin
               rv[7:0] = q.rx_hold;
               d.flags[`TWC_FLAG_RX_READY] = 1'b0;
            end
            `TWC_OFS_TRANSMIT_HOLDING: begin
               rv[7:0] = q.tx_hold;
            end
            default: begin
               // Write-only and unmapped words read as zero
            end
         endcase
         d.hrdata = rv;
      end

      // ----------------------------------------
      // Frame sequencer
      // ----------------------------------------
      // Data changes on the falling tick; the bit clocked in the
      // high phase is the synchronised level at that same tick.
      // Bus effects above come first, so hardware sets win.
      case (q.st)
         ST_IDLE: begin
            if (start_cmd && q.master_transfer_enable) begin
               d.st = ST_START;
               d.sda_pull = 1'b1;
               d.flags[`TWC_FLAG_COMPLETE] = 1'b0;
               // Read bit only when no internal address goes first
               d.shifter = {d.slave_device_address,
                            d.read_direction_bit &&
                            (d.internal_address_size == 2'h0)};
               d.ia_left = d.internal_address_size;
               d.kind = K_ADDR;
               d.last_rx = 1'b0;
            end
         end
         ST_START: begin
            // First low phase after the start: put out the MSB
            if (fall) begin
               d.st = ST_BYTE;
               d.idx = 4'h0;
               d.sda_pull = ~q.shifter[7];
            end
         end
         ST_BYTE: begin
            if (fall) begin
               if (q.idx < 4'h7) begin
                  // Data bit done, next one MSB first
                  d.idx = q.idx + 4'h1;
                  if (q.kind == K_RXD) begin
                     d.shifter = {q.shifter[6:0], bit_in};
                     d.sda_pull = 1'b0;
                  end else begin
                     d.shifter = {q.shifter[6:0], 1'b0};
                     d.sda_pull = ~q.shifter[6];
                  end
               end else if (q.idx == 4'h7) begin
                  // Last data bit done: acknowledge slot follows
                  d.idx = 4'h8;
                  if (q.kind == K_RXD) begin
                     d.rx_hold = {q.shifter[6:0], bit_in};
                     if (q.flags[`TWC_FLAG_RX_READY]) begin
                        d.flags[`TWC_FLAG_OVERRUN] = 1'b1;
                     end
                     d.flags[`TWC_FLAG_RX_READY] = 1'b1;
                     // A pending stop makes this the last byte: no ack
                     d.last_rx = d.stop_req;
                     d.sda_pull = ~d.stop_req;
                  end else begin
                     d.sda_pull = 1'b0;
                  end
               end else begin
                  // Acknowledge slot done
                  d.idx = 4'h0;
                  if (q.kind == K_RXD) begin
                     if (q.last_rx) begin
                        d = go_stop(d);
                     end else begin
                        d.sda_pull = 1'b0;
                     end
                  end else if (bit_in) begin
                     // Slave left the line high
                     d.flags[`TWC_FLAG_NOT_ACKED] = 1'b1;
                     d.flags[`TWC_FLAG_COMPLETE] = 1'b1;
                     d.flags[`TWC_FLAG_TX_READY] = 1'b1;
                     d = go_stop(d);
                  end else if (q.kind == K_TXD) begin
                     d = load_data(d);
                  end else if (q.ia_left != 2'h0) begin
                     // Address acked: internal address, upper byte first
                     d.shifter = ia_byte(q.internal_address_value, q.ia_left);
                     d.ia_left = q.ia_left - 2'h1;
                     d.kind = K_IADDR;
                     d.sda_pull = ~d.shifter[7];
                  end else if (q.read_direction_bit) begin
                     if (q.kind == K_ADDR) begin
                        d.kind = K_RXD;
                        d.sda_pull = 1'b0;
                     end else begin
                        // Internal address sent: restart to read
                        d.st = ST_RSTART;
                        d.sda_pull = 1'b0;
                     end
                  end else begin
                     d = load_data(d);
                  end
               end
            end
         end
         ST_RSTART: begin
            // Clock parked high with data released: pull data low
            if (park_tick) begin
               d.st = ST_START;
               d.sda_pull = 1'b1;
               d.shifter = {q.slave_device_address, 1'b1};
               d.kind = K_ADDR;
               d.ia_left = 2'h0;
            end
         end
         ST_STOP: begin
            // Clock parked high: data rises, frame ends
            if (park_tick) begin
               d.st = ST_IDLE;
               d.sda_pull = 1'b0;
               d.stop_req = 1'b0;
               d.flags[`TWC_FLAG_COMPLETE] = 1'b1;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase

      // Software reset loads the reset image; the clock generator is not reset and idles one cycle later
      if (soft_reset) begin
         d = CTL_RST;
      end

      d.irq = |(d.flags & d.irq_mask);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= CTL_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Clock generator
   // ----------------------------------------
   assign sc.en = (q.st != ST_IDLE);
   assign sc.park = (q.st == ST_STOP) || (q.st == ST_RSTART);
   assign sc.scl_seen = q.scl_s2;
   assign sc.low_div = q.low_phase_divider;
   assign sc.high_div = q.high_phase_divider;
   assign sc.div_exp = q.clock_divider_exponent;

   twc_scl_gen u_gen (
      .hclk(hclk),
      .hresetn(hresetn),
      .sc(sc)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Open-drain: the drive level is always low, the enable pulls
   assign serial_clock_line_o = 1'b0;
   assign serial_clock_line_oe = sc.scl_pull;
   assign serial_data_line_o = 1'b0;
   assign serial_data_line_oe = q.sda_pull;
   assign hreadyout = q.hreadyout;
   assign hrdata = q.hrdata;
   assign hresp = 1'b0;
   assign irq = q.irq;
endmodule

/* File: twc_slave_model.sv */
`timescale 1ns/1ps
// Far-side target: acks what it receives, leaves the data line alone on reads
module twc_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic refuse,
   output logic pull,
   output logic [31:0] seen
);
   int n = 0;
   logic first = 1'b0;
   logic rd = 1'b0;
   logic [7:0] sh = 8'h00;
   initial pull = 1'b0;
   initial seen = 32'h0000_0000;
   // Start: data falls while clock high
   always @(negedge sda) if (scl) begin
      n = 0;
      first = 1'b1;
   end
   // Bits are sampled on the rising clock
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      if (n == 8) seen = {seen[23:0], sh};
      if (n == 8 && first) rd = sh[0];
   end
   // Ack slot follows the ninth fall; never ack in the master's slot on reads
   always @(negedge scl) begin
      first = first && n != 9;
      n = (n == 9) ? 1 : n + 1;
      pull = n == 9 && !refuse && (first || !rd);
   end
endmodule

/* File: twc_two_wire_controller_sva.sv */
`timescale 1ns/1ps
module twc_two_wire_controller_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic serial_clock_line_oe,
   input wire logic serial_data_line_oe,
   input wire logic irq
);
   logic rp, wp, busy, hok, so, nk;
   logic [7:0] a;
   logic [8:0] msk;
   logic [18:0] cw;
   logic [15:0] lo, hi;
   wire scl = serial_clock_line_oe;
   wire sda = serial_data_line_oe;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Shadow of bus writes, phase counters and frame tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rp, wp, busy, hok, so, nk, a, msk, cw, lo, hi} <= '0;
      end else begin
         if (hsel && htrans[1] && hready && hsize == 3'h2) begin
            rp <= !hwrite;
            wp <= hwrite;
            a <= haddr[7:0];
         end else if (hready) begin
            rp <= 1'b0;
            wp <= 1'b0;
         end
         if (wp && a == 8'h10) cw <= hwdata[18:0];
         if (wp && a == 8'h24) msk <= msk | (hwdata[8:0] & 9'h1C7);
         if (wp && a == 8'h28) msk <= msk & ~hwdata[8:0];
         lo <= scl ? lo + 16'h0001 : 16'h0000;
         hi <= scl ? 16'h0000 : hi + 16'h0001;
         so <= sda;
         // Data moving while clock high marks start or stop
         if (!scl && sda != so) busy <= sda;
         hok <= scl ? 1'b1 : (sda != so) ? 1'b0 : hok;
         // A refused byte sets complete before its stop has gone out
         if (!busy) nk <= 1'b0;
         else if (rp && hready && a == 8'h20 && hrdata[8]) nk <= 1'b1;
      end
   end
   sequence rd_done(logic [7:0] x);
      rp && hready && a == x;
   endsequence
   AST_LOW_PHASE: assert property (
      $fell(scl) |-> lo == (16'(cw[7:0]) << cw[18:16]) + 16'h0003)
      else $error("clock low phase length wrong");
   AST_HIGH_PHASE: assert property (
      $rose(scl) && hok |-> hi == (16'(cw[15:8]) << cw[18:16]) + 16'h0003)
      else $error("clock high phase length wrong");
   AST_DONE_IN_FRAME: assert property (
      rd_done(8'h20) ##0 (busy && !nk) |-> !hrdata[0] || hrdata[8])
      else $error("complete flag set inside a frame");
   AST_MASK_READ: assert property (rd_done(8'h2C) |-> hrdata == {23'h0, msk})
      else $error("mask read differs from enables written");
   AST_RHR_UPPER: assert property (rd_done(8'h30) |-> hrdata[31:8] == 24'h0)
      else $error("receive holding upper bits not zero");
   AST_IRQ_MASKED: assert property ((msk == 9'h000) [*2] |-> !irq)
      else $error("interrupt with every source disabled");
   // Inside a frame data may only move with the clock parked past its high phase
   AST_DATA_STABLE: assert property (
      !scl && $changed(sda) && busy |-> hi > (16'(cw[15:8]) << cw[18:16]) + 16'h0003)
      else $error("data moved while clock high inside a frame");
   AST_IDLE_NO_CLOCK: assert property (!busy |-> !scl)
      else $error("clock driven outside a frame");
endmodule

/* File: twc_two_wire_controller_tb.sv */
`timescale 1ns/1ps
module twc_two_wire_controller_tb;
   import twc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, refuse, pull;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seen;
   logic serial_clock_line_o, serial_clock_line_oe, serial_data_line_o, serial_data_line_oe;
   // Pulled-up wires: low while any party pulls
   wire serial_clock_line_i = !serial_clock_line_oe;
   wire serial_data_line_i = !(serial_data_line_oe || pull);
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   twc_two_wire_controller uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .serial_clock_line_i,
      .serial_clock_line_o, .serial_clock_line_oe, .serial_data_line_i,
      .serial_data_line_o, .serial_data_line_oe, .irq);
   twc_slave_model slv (.scl(serial_clock_line_i), .sda(serial_data_line_i), .refuse,
      .pull, .seen);
   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // One single word transfer; waits on hready for both phases
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, ad, d, x);
   endtask
   task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, ad, 32'h0, x);
      check(nm, x, e);
   endtask
   // Frame end seen as the complete interrupt dropping then rising
   task automatic wait_done();
      do @(posedge hclk); while (irq !== 1'b0);
      do @(posedge hclk); while (irq !== 1'b1);
   endtask
   task automatic t_reset();
      rdc("status", 8'h20, 32'h0);
      rdc("mask", 8'h2C, 32'h0);
   endtask
   task automatic t_irq();
      wr(8'h24, 32'h1FF);
      rdc("mask", 8'h2C, 32'h1C7);
      wr(8'h28, 32'h1C6);
      rdc("mask", 8'h2C, 32'h001);
      wr(8'h00, 32'h4);
      rdc("status", 8'h20, 32'h5);
      check("irq", {31'h0, irq}, 32'h1);
   endtask
   task automatic t_write();
      int lo, hi;
      lo = 0;
      hi = 0;
      wr(8'h10, 32'h0001_0102);
      rdc("clock", 8'h10, 32'h0001_0102);
      wr(8'h04, 32'h0055_0200);
      rdc("mode", 8'h04, 32'h0055_0200);
      wr(8'h0C, 32'h0012_ABCD);
      wr(8'h34, 32'h3C);
      rdc("status", 8'h20, 32'h0);
      while (serial_clock_line_oe !== 1'b1) @(posedge hclk);
      while (serial_clock_line_oe === 1'b1) begin
         @(posedge hclk);
         lo++;
      end
      while (serial_clock_line_oe === 1'b0) begin
         @(posedge hclk);
         hi++;
      end
      check("low", lo, 7);
      check("high", hi, 5);
      wait_done();
      check("bytes", seen, 32'hAAAB_CD3C);
      rdc("status", 8'h20, 32'h85);
      rdc("status", 8'h20, 32'h05);
   endtask
   task automatic t_not_acknowledged_flag();
      refuse <= 1'b1;
      wr(8'h34, 32'h11);
      wait_done();
      rdc("status", 8'h20, 32'h105);
      rdc("status", 8'h20, 32'h005);
      // Complete rises with the refusal; the stop still has to go out
      while (serial_data_line_oe !== 1'b0) @(posedge hclk);
      refuse <= 1'b0;
   endtask
   task automatic t_read();
      wr(8'h04, 32'h0055_1000);
      wr(8'h00, 32'h3);
      wait_done();
      rdc("status", 8'h20, 32'h007);
      check("bytes", {16'h0, seen[15:0]}, 32'hABFF);
      wr(8'h00, 32'h3);
      wait_done();
      rdc("status", 8'h20, 32'h047);
      rdc("status", 8'h20, 32'h007);
      rdc("rhr", 8'h30, 32'hFF);
      rdc("status", 8'h20, 32'h005);
   endtask
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      {hresetn, hsel, htrans, hwrite, haddr, hwdata, refuse} = '0;
      hsize = 3'h2;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_irq();
      t_write();
      t_not_acknowledged_flag();
      t_read();
      end_sim();
   end
endmodule
bind twc_two_wire_controller twc_two_wire_controller_sva chk (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .serial_clock_line_oe,
   .serial_data_line_oe, .irq);
